// file: hdl/tpw_params.svh
// register map, bit positions and constants of the timer block
// assumes an 8-bit classic wishbone slave indexed by word
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH
// register indices on the wishbone address
`define TPW_R_T0CNT 5'h00
`define TPW_R_T0MODE 5'h01
`define TPW_R_PWRCTL 5'h02
`define TPW_R_IRQEN 5'h03
`define TPW_R_IRQFLG 5'h04
`define TPW_R_T1CTL1 5'h05
`define TPW_R_T1CTL2 5'h06
`define TPW_R_T1LOW 5'h07
`define TPW_R_THIGH 5'h08
`define TPW_R_DUTY1 5'h09
`define TPW_R_BZ1CTL 5'h0a
`define TPW_R_PS1CNT 5'h0b
`define TPW_R_T2CTL1 5'h0c
`define TPW_R_T2CTL2 5'h0d
`define TPW_R_T2LOW 5'h0e
`define TPW_R_DUTY2 5'h0f
`define TPW_R_PS2CNT 5'h10
// bit positions shared by the control registers
`define TPW_B_EN 0
`define TPW_B_RL 1
`define TPW_B_OS 2
`define TPW_B_PSN 3
`define TPW_B_EDGE 4
`define TPW_B_SRC 5
`define TPW_B_POL 6
`define TPW_B_TOP 7
// flag positions in the interrupt flag register
`define TPW_F_T0 0
`define TPW_F_T1 3
`define TPW_F_T2 5
`define TPW_IRQ_MASK 8'h29
// values
`define TPW_ZERO8 8'h00
`define TPW_MAX8 8'hff
`define TPW_ZERO10 10'h000
`define TPW_ONE10 10'h001
`define TPW_MAX10 10'h3ff
// instruction clock enable: one pulse every TPW_INSTR_DIV+1 ref clocks
`define TPW_INSTR_DIV 2'h1
`endif

// file: hdl/tpw_pkg.sv
// types of the timer block
// assumes tpw_params.svh for all constants
package tpw_pkg;
  // complete register state of the block
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [1:0] idiv;
    logic [2:0] sa, sb, sl;
    logic [7:0] t0cnt, timer0_mode_reg, pcon, irq_enable_reg, irq_flag_reg, ps0;
    logic [7:0] timer1_control_1, timer1_control_2, thigh, d1low, buzzer1_control, bz1cnt, ps1;
    logic [9:0] t1rel, t1cnt, d1;
    logic t1stop;
    logic [7:0] t2cr1, t2cr2, d2low, ps2;
    logic [9:0] t2rel, t2cnt, d2;
    logic t2stop;
    logic pb3, pb3oe, pb2, pb2oe, irq;
  } tpw_state_t;
endpackage

// file: hdl/tpw_top.sv
// timer0, timer1 with pwm1 and buzzer1, timer2 with pwm2
// assumes asynchronous clock pins and a classic 8-bit wishbone master
//
// Operation
// - timer0 counts up eight bits when enabled; writes load it, reads show it
// - timer0 clock: instruction clock, pin a, or low oscillator by two bits
// - timer0 edge bit picks falling (1) or rising (0) external edges
// - prescaler0 divides when assign bit is 0; writing 0 clears it
// - prescaler0 ratio field gives 1:2 to 1:256 in powers of two
// - timer0 overflow sets flag bit 0; only a written 0 clears it
// - timer1 reload double buffered; loads at underflow, or at once when disabled
// - timer1 enable, source pin a or instruction clock, edge select
// - prescaler1 active when enable_n is 0, ratio 1:2..1:256, count readable
// - timer1 one-shot stops at zero; else restarts from reload or 0x3ff
// - timer1 underflow sets flag bit 3 until a written 0
// - pwm1 drives pin b3 when enabled; polarity bit makes it active low
// - pwm1 duty counts active timer1 clocks; duty must not exceed reload
// - pwm1 duty high bits first; new duty applies at timer1 underflow
// - buzzer1 divides prescaler1 or timer1 output by 1:2..1:256 on pin b3
// - with pwm1 and buzzer1 both enabled, pwm1 owns the pin
// - timer2 reload double buffered like timer1, high bits 7:6
// - timer2 enable, source pin b, edge, prescaler2 as for timer1
// - timer2 one-shot or continuous with reload or 0x3ff restart
// - timer2 underflow sets flag bit 5 until a written 0
// - pwm2 works like pwm1 on timer2, pin b2, duty high bits 3:2
// - global enable gates every timer interrupt with its own enable
// - external clock b comes from port a pin 1
`timescale 1ns/100ps
`default_nettype none
`include "tpw_params.svh"

module tpw_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [4:0] I_WB_ADR,
  input wire logic [7:0] I_WB_DAT,
  input wire logic I_WB_SEL,
  output logic [7:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_EXT_CLOCK_PIN_A,
  input wire logic I_PORT_A_PIN_1,
  input wire logic I_LOW_OSC,
  output logic O_PORT_B_PIN_3,
  output logic O_PORT_B_PIN_3_OE,
  output logic O_PORT_B_PIN_2,
  output logic O_PORT_B_PIN_2_OE,
  output logic O_IRQ
);

  // prescaler tap: fires when the low sel+1 count bits are all ones
  function automatic logic ps_tap(input logic [7:0] cnt,
                                  input logic [2:0] sel);
    logic [7:0] mask;
    mask = `TPW_MAX8 >> (3'h7 - sel);
    return (cnt & mask) == mask;
  endfunction

  // edge seen between second and third sync stage
  function automatic logic edge_hit(input logic [1:0] sy,
                                    input logic fall);
    return fall ? (sy[1] & ~sy[0]) : (~sy[1] & sy[0]);
  endfunction

  // one down-count step: {underflow, next count}
  function automatic logic [10:0] dn_step(input logic [9:0] cnt,
                                          input logic [9:0] rel,
                                          input logic [7:0] cr1);
    logic uf;
    logic [9:0] nxt;
    uf = (cnt == `TPW_ZERO10);
    if (!uf) begin
      nxt = cnt - `TPW_ONE10;
    end else if (cr1[`TPW_B_OS]) begin
      nxt = cnt;
    end else if (cr1[`TPW_B_RL]) begin
      nxt = rel;
    end else begin
      nxt = `TPW_MAX10;
    end
    return {uf, nxt};
  endfunction

  tpw_pkg::tpw_state_t s;
  tpw_pkg::tpw_state_t next_s;
  logic instr_tick;
  logic req;
  logic wr;
  logic ext_a_edge;
  logic low_edge;
  logic t0_src;
  logic t0_go;
  logic t1_src;
  logic t1_ps;
  logic t1_go;
  logic t1_uf;
  logic t2_src;
  logic t2_ps;
  logic t2_go;
  logic t2_uf;
  logic [10:0] t1_step;
  logic [10:0] t2_step;
  logic pwm1_lvl;
  logic pwm2_lvl;
  logic bz1_src;
  logic bz1_lvl;

  // bus decode; writes land on the edge that the master samples ack
  assign req = I_WB_CYC & I_WB_STB;
  assign wr = req & s.ack & I_WB_WE & I_WB_SEL;
  assign instr_tick = (s.idiv == `TPW_INSTR_DIV);

  // timer0 clock choice and prescaler0
  assign ext_a_edge = edge_hit(s.sa[2:1], s.timer0_mode_reg[`TPW_B_EDGE]);
  assign low_edge = edge_hit(s.sl[2:1], s.timer0_mode_reg[`TPW_B_EDGE]);
  assign t0_src = s.pcon[`TPW_B_EN] & (!s.timer0_mode_reg[`TPW_B_SRC] ? instr_tick :
                  s.timer0_mode_reg[`TPW_B_TOP] ? low_edge : ext_a_edge);
  assign t0_go = t0_src & (s.timer0_mode_reg[`TPW_B_PSN] |
                           ps_tap(s.ps0, s.timer0_mode_reg[2:0]));

  // timer1 source, prescaler1 and step
  assign t1_src = s.timer1_control_1[`TPW_B_EN] & (s.timer1_control_2[`TPW_B_SRC] ?
                  edge_hit(s.sa[2:1], s.timer1_control_2[`TPW_B_EDGE]) : instr_tick);
  assign t1_ps = t1_src & ps_tap(s.ps1, s.timer1_control_2[2:0]);
  assign t1_go = ~s.t1stop & (s.timer1_control_2[`TPW_B_PSN] ? t1_src : t1_ps);
  assign t1_step = dn_step(s.t1cnt, s.t1rel, s.timer1_control_1);
  assign t1_uf = t1_go & t1_step[10];

  // timer2 on the port a pin 1 clock
  assign t2_src = s.t2cr1[`TPW_B_EN] & (s.t2cr2[`TPW_B_SRC] ?
                  edge_hit(s.sb[2:1], s.t2cr2[`TPW_B_EDGE]) : instr_tick);
  assign t2_ps = t2_src & ps_tap(s.ps2, s.t2cr2[2:0]);
  assign t2_go = ~s.t2stop & (s.t2cr2[`TPW_B_PSN] ? t2_src : t2_ps);
  assign t2_step = dn_step(s.t2cnt, s.t2rel, s.t2cr1);
  assign t2_uf = t2_go & t2_step[10];

  // pwm active while the count sits below the duty
  assign pwm1_lvl = (s.t1cnt < s.d1) ^ s.timer1_control_1[`TPW_B_POL];
  assign pwm2_lvl = (s.t2cnt < s.d2) ^ s.t2cr1[`TPW_B_POL];

  // buzzer1 halves a toggle counter tap
  assign bz1_src = s.buzzer1_control[3] ? t1_uf : t1_ps;
  assign bz1_lvl = s.bz1cnt[s.buzzer1_control[2:0]];

  // next state of the whole block
  always_comb begin
    logic [7:0] set_f;
    set_f = `TPW_ZERO8;
    next_s = s;
    // two flops before any edge logic
    next_s.sa = {s.sa[1:0], I_EXT_CLOCK_PIN_A};
    next_s.sb = {s.sb[1:0], I_PORT_A_PIN_1};
    next_s.sl = {s.sl[1:0], I_LOW_OSC};
    next_s.idiv = instr_tick ? 2'h0 : 2'(s.idiv + 1'b1);

    // timer0 with prescaler0
    if (t0_src & ~s.timer0_mode_reg[`TPW_B_PSN]) begin
      next_s.ps0 = 8'(s.ps0 + 1'b1);
    end
    if (t0_go) begin
      next_s.t0cnt = 8'(s.t0cnt + 1'b1);
      if (s.t0cnt == `TPW_MAX8) begin
        set_f[`TPW_F_T0] = 1'b1;
      end
    end

    // timer1 down count and reload
    if (t1_src & ~s.timer1_control_2[`TPW_B_PSN]) begin
      next_s.ps1 = 8'(s.ps1 + 1'b1);
    end
    if (t1_go) begin
      next_s.t1cnt = t1_step[9:0];
    end
    if (t1_uf) begin
      set_f[`TPW_F_T1] = 1'b1;
      next_s.d1 = {s.thigh[1:0], s.d1low};
      next_s.t1stop = s.timer1_control_1[`TPW_B_OS];
    end
    if (bz1_src) begin
      next_s.bz1cnt = 8'(s.bz1cnt + 1'b1);
    end

    // timer2 down count and reload
    if (t2_src & ~s.t2cr2[`TPW_B_PSN]) begin
      next_s.ps2 = 8'(s.ps2 + 1'b1);
    end
    if (t2_go) begin
      next_s.t2cnt = t2_step[9:0];
    end
    if (t2_uf) begin
      set_f[`TPW_F_T2] = 1'b1;
      next_s.d2 = {s.thigh[3:2], s.d2low};
      next_s.t2stop = s.t2cr1[`TPW_B_OS];
    end

    // register writes win over counting, not over flag sets
    if (wr) begin
      case (I_WB_ADR)
        `TPW_R_T0CNT: next_s.t0cnt = I_WB_DAT;
        `TPW_R_T0MODE: begin
          next_s.timer0_mode_reg = I_WB_DAT;
          if (!I_WB_DAT[`TPW_B_PSN]) begin
            next_s.ps0 = `TPW_ZERO8;
          end
        end
        `TPW_R_PWRCTL: next_s.pcon = I_WB_DAT;
        `TPW_R_IRQEN: next_s.irq_enable_reg = I_WB_DAT;
        `TPW_R_IRQFLG: next_s.irq_flag_reg = I_WB_DAT;
        `TPW_R_T1CTL1: begin
          next_s.timer1_control_1 = I_WB_DAT;
          next_s.t1stop = 1'b0;
        end
        `TPW_R_T1CTL2: next_s.timer1_control_2 = I_WB_DAT;
        `TPW_R_T1LOW: begin
          next_s.t1rel = {s.thigh[5:4], I_WB_DAT};
          next_s.t1stop = 1'b0;
          if (!s.timer1_control_1[`TPW_B_EN]) begin
            next_s.t1cnt = {s.thigh[5:4], I_WB_DAT};
          end
        end
        `TPW_R_THIGH: next_s.thigh = I_WB_DAT;
        `TPW_R_DUTY1: next_s.d1low = I_WB_DAT;
        `TPW_R_BZ1CTL: next_s.buzzer1_control = I_WB_DAT;
        `TPW_R_T2CTL1: begin
          next_s.t2cr1 = I_WB_DAT;
          next_s.t2stop = 1'b0;
        end
        `TPW_R_T2CTL2: next_s.t2cr2 = I_WB_DAT;
        `TPW_R_T2LOW: begin
          next_s.t2rel = {s.thigh[7:6], I_WB_DAT};
          next_s.t2stop = 1'b0;
          if (!s.t2cr1[`TPW_B_EN]) begin
            next_s.t2cnt = {s.thigh[7:6], I_WB_DAT};
          end
        end
        `TPW_R_DUTY2: next_s.d2low = I_WB_DAT;
        default: next_s.timer0_mode_reg = s.timer0_mode_reg;
      endcase
    end
    // a set in the clearing cycle is kept
    next_s.irq_flag_reg = next_s.irq_flag_reg | set_f;

    // one-cycle ack, read data captured with it
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      case (I_WB_ADR)
        `TPW_R_T0CNT: next_s.rdat = s.t0cnt;
        `TPW_R_T0MODE: next_s.rdat = s.timer0_mode_reg;
        `TPW_R_PWRCTL: next_s.rdat = s.pcon;
        `TPW_R_IRQEN: next_s.rdat = s.irq_enable_reg;
        `TPW_R_IRQFLG: next_s.rdat = s.irq_flag_reg;
        `TPW_R_T1CTL1: next_s.rdat = s.timer1_control_1;
        `TPW_R_T1CTL2: next_s.rdat = s.timer1_control_2;
        `TPW_R_T1LOW: next_s.rdat = s.t1cnt[7:0];
        `TPW_R_THIGH: next_s.rdat = {s.t2cnt[9:8], s.t1cnt[9:8],
                                     s.thigh[3:0]};
        `TPW_R_DUTY1: next_s.rdat = s.d1low;
        `TPW_R_BZ1CTL: next_s.rdat = s.buzzer1_control;
        `TPW_R_PS1CNT: next_s.rdat = s.ps1;
        `TPW_R_T2CTL1: next_s.rdat = s.t2cr1;
        `TPW_R_T2CTL2: next_s.rdat = s.t2cr2;
        `TPW_R_T2LOW: next_s.rdat = s.t2cnt[7:0];
        `TPW_R_DUTY2: next_s.rdat = s.d2low;
        `TPW_R_PS2CNT: next_s.rdat = s.ps2;
        default: next_s.rdat = `TPW_ZERO8;
      endcase
    end

    // pins: pwm1 outranks buzzer1 on b3
    next_s.pb3oe = s.timer1_control_1[`TPW_B_TOP] | s.buzzer1_control[`TPW_B_TOP];
    next_s.pb3 = s.timer1_control_1[`TPW_B_TOP] ? pwm1_lvl :
                 (s.buzzer1_control[`TPW_B_TOP] & bz1_lvl);
    next_s.pb2oe = s.t2cr1[`TPW_B_TOP];
    next_s.pb2 = s.t2cr1[`TPW_B_TOP] & pwm2_lvl;
    // global enable gates all three sources
    next_s.irq = s.pcon[`TPW_B_TOP] &
                 (|(s.irq_flag_reg & s.irq_enable_reg & `TPW_IRQ_MASK));
  end

  // the single state register
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // all outputs straight from state flops
  assign O_WB_DAT = s.rdat;
  assign O_WB_ACK = s.ack;
  assign O_PORT_B_PIN_3 = s.pb3;
  assign O_PORT_B_PIN_3_OE = s.pb3oe;
  assign O_PORT_B_PIN_2 = s.pb2;
  assign O_PORT_B_PIN_2_OE = s.pb2oe;
  assign O_IRQ = s.irq;

  // checks
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  ack_pulse_a: assert property (
    s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");

  t0_overflow_a: assert property (
    t0_go && s.t0cnt == `TPW_MAX8 && !wr
    |=> s.irq_flag_reg[`TPW_F_T0] && s.t0cnt == `TPW_ZERO8)
    else $error("timer0 wrap did not set its flag");

  ps0_clear_a: assert property (
    wr && I_WB_ADR == `TPW_R_T0MODE && !I_WB_DAT[`TPW_B_PSN]
    |=> s.ps0 == `TPW_ZERO8)
    else $error("prescaler0 not cleared");

  t1_flag_hold_a: assert property (
    s.irq_flag_reg[`TPW_F_T1] && !(wr && I_WB_ADR == `TPW_R_IRQFLG)
    |=> s.irq_flag_reg[`TPW_F_T1])
    else $error("timer1 flag lost without a write");

  t1_restart_a: assert property (
    t1_uf && !s.timer1_control_1[`TPW_B_OS] && !s.timer1_control_1[`TPW_B_RL] && !wr
    |=> s.t1cnt == `TPW_MAX10 && s.irq_flag_reg[`TPW_F_T1])
    else $error("timer1 did not restart from full count");

  t1_idle_load_a: assert property (
    wr && I_WB_ADR == `TPW_R_T1LOW && !s.timer1_control_1[`TPW_B_EN]
    |=> s.t1cnt == {$past(s.thigh[5:4]), $past(I_WB_DAT)})
    else $error("disabled timer1 did not load at once");

  duty_update_a: assert property (
    $changed(s.d1) |-> $past(t1_uf))
    else $error("pwm1 duty changed away from underflow");

  pin_priority_a: assert property (
    s.timer1_control_1[`TPW_B_TOP] |=> s.pb3oe && s.pb3 == $past(pwm1_lvl))
    else $error("pwm1 does not own pin b3");

  t2_one_shot_a: assert property (
    t2_uf && s.t2cr1[`TPW_B_OS] && !wr
    |=> s.t2stop && s.t2cnt == `TPW_ZERO10 ##1 !t2_go)
    else $error("timer2 one-shot kept running");

  irq_gate_a: assert property (
    !s.pcon[`TPW_B_TOP] |=> !s.irq)
    else $error("interrupt without global enable");

  t0_wrap_c: cover property (t0_go && s.t0cnt == `TPW_MAX8);
  t1_reload_c: cover property (t1_uf && s.timer1_control_1[`TPW_B_RL]);
  buzz_pin_c: cover property (s.pb3 && !s.timer1_control_1[`TPW_B_TOP]);
  t2_shot_c: cover property (t2_uf && s.t2cr1[`TPW_B_OS]);

endmodule // tpw_top
`default_nettype wire

// file: sim/tpw_pins.sv
// partner model: external clock sources feeding the timer pins
// assumes the bench calls burst() and the reference clock runs
`timescale 1ns/100ps
`default_nettype none

module tpw_pins (
  input wire logic i_clk,
  output var logic o_pin_a,
  output var logic o_pin_b,
  output var logic o_low
);
  // all sources idle low; they stand still outside a burst
  initial begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0; // port a pin 1 feeds clock b
    o_low = 1'b0;
  end

  // n full pulses, each level held 3 ref clocks so the synchroniser sees it
  task automatic burst(input int sel, input int n);
    repeat (n) begin
      repeat (3) @(posedge i_clk);
      if (sel == 0) o_pin_a <= 1'b1; else if (sel == 1) o_pin_b <= 1'b1; else o_low <= 1'b1;
      repeat (3) @(posedge i_clk);
      if (sel == 0) o_pin_a <= 1'b0; else if (sel == 1) o_pin_b <= 1'b0; else o_low <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
  endtask
endmodule // tpw_pins

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the timer, pwm and buzzer block
// assumes tpw_top with an 8-bit classic wishbone slave and tpw_pins
`timescale 1ns/100ps
`default_nettype none
`include "tpw_params.svh"

module testbench;
  logic clk, rst, cyc, stb, we, sel, ack, p3, p3oe, p2, p2oe, irq;
  logic [4:0] adr;
  logic [7:0] wdat, rdat, q;
  logic pa, pb, lo;
  int error_cnt, n_compared, cyc_cnt;

  tpw_top tpw_top_i (.I_REF_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_EXT_CLOCK_PIN_A(pa), .I_PORT_A_PIN_1(pb), .I_LOW_OSC(lo),
    .O_PORT_B_PIN_3(p3), .O_PORT_B_PIN_3_OE(p3oe), .O_PORT_B_PIN_2(p2),
    .O_PORT_B_PIN_2_OE(p2oe), .O_IRQ(irq));
  tpw_pins tpw_pins_i (.i_clk(clk), .o_pin_a(pa), .o_pin_b(pb), .o_low(lo));

  // 25 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) error_cnt++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  // counts clocks with the chosen pin high over a window
  task automatic high_cnt(input logic pin2, input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge clk);
      #1 if ((pin2 ? p2 : p3) === 1'b1) h++;
    end
  endtask

  task automatic t_timer0();
    wr(`TPW_R_T0MODE, 8'h08); // instruction clock, no prescale
    wr(`TPW_R_T0CNT, 8'hfe);
    wr(`TPW_R_IRQEN, 8'h01);
    wr(`TPW_R_PWRCTL, 8'h81);
    repeat (12) @(posedge clk);
    chk(irq, 1'b1);
    wr(`TPW_R_PWRCTL, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rd_chk(`TPW_R_IRQFLG, 8'h01);
    wr(`TPW_R_IRQFLG, 8'h00);
    rd_chk(`TPW_R_IRQFLG, 8'h00);
    // pin a, falling edges, no prescale
    wr(`TPW_R_T0MODE, 8'h38);
    wr(`TPW_R_T0CNT, 8'h00);
    wr(`TPW_R_PWRCTL, 8'h01);
    tpw_pins_i.burst(0, 5);
    rd_chk(`TPW_R_T0CNT, 8'h05);
    // low oscillator on rising edges with ratio 1:8, above 4 as advised
    wr(`TPW_R_T0MODE, 8'ha2);
    wr(`TPW_R_T0CNT, 8'h00);
    tpw_pins_i.burst(2, 16);
    rd_chk(`TPW_R_T0CNT, 8'h02);
    wr(`TPW_R_PWRCTL, 8'h00);
    $display("timer0 test done");
  endtask

  task automatic t_timer1();
    wr(`TPW_R_THIGH, 8'h00); // high bits before low byte
    wr(`TPW_R_T1LOW, 8'h03);
    rd_chk(`TPW_R_T1LOW, 8'h03);
    wr(`TPW_R_T1CTL2, 8'h08);
    wr(`TPW_R_IRQEN, 8'h08);
    wr(`TPW_R_PWRCTL, 8'h80);
    wr(`TPW_R_T1CTL1, 8'h03);
    repeat (12) @(posedge clk);
    chk(irq, 1'b1);
    rd_chk(`TPW_R_IRQFLG, 8'h08);
    wr(`TPW_R_T1CTL1, 8'h05);
    repeat (20) @(posedge clk);
    rd_chk(`TPW_R_T1LOW, 8'h00);
    wr(`TPW_R_IRQFLG, 8'h00);
    rd_chk(`TPW_R_IRQFLG, 8'h00);
    wr(`TPW_R_T1CTL1, 8'h01);
    repeat (20) @(posedge clk);
    wb(1'b0, `TPW_R_THIGH, 8'h00);
    chk(q[5:4], 2'h3);
    wr(`TPW_R_T1CTL1, 8'h00);
    // pin a rising edges through prescaler1 at 1:2: five edges give two steps
    wr(`TPW_R_T1LOW, 8'h10); // loads at once while disabled
    wr(`TPW_R_T1CTL2, 8'h20);
    wr(`TPW_R_T1CTL1, 8'h01);
    tpw_pins_i.burst(0, 5);
    rd_chk(`TPW_R_PS1CNT, 8'h05);
    rd_chk(`TPW_R_T1LOW, 8'h0e);
    wr(`TPW_R_T1CTL1, 8'h00);
    wr(`TPW_R_T1CTL2, 8'h08); // later scenarios expect no prescaler
    $display("timer1 test done");
  endtask

  task automatic t_pwm();
    int h;
    wr(`TPW_R_THIGH, 8'h00);
    wr(`TPW_R_DUTY1, 8'h04);
    wr(`TPW_R_T1LOW, 8'h09);
    wr(`TPW_R_T1CTL1, 8'h83);
    repeat (60) @(posedge clk);
    high_cnt(1'b0, 40, h);
    chk(h, 16);
    chk(p3oe, 1'b1);
    wr(`TPW_R_T1CTL1, 8'hc3);
    wr(`TPW_R_BZ1CTL, 8'h88);
    repeat (40) @(posedge clk);
    high_cnt(1'b0, 40, h);
    chk(h, 24);
    wr(`TPW_R_T1CTL1, 8'h03);
    repeat (50) @(posedge clk);
    high_cnt(1'b0, 80, h);
    chk(h, 40);
    chk(p3oe, 1'b1);
    wr(`TPW_R_BZ1CTL, 8'h00);
    wr(`TPW_R_T1CTL1, 8'h00);
    wr(`TPW_R_T2CTL2, 8'h08);
    wr(`TPW_R_DUTY2, 8'h04);
    wr(`TPW_R_T2LOW, 8'h09);
    wr(`TPW_R_T2CTL1, 8'h83);
    repeat (60) @(posedge clk);
    high_cnt(1'b1, 40, h);
    chk(h, 16);
    chk(p2oe, 1'b1);
    wr(`TPW_R_T2CTL1, 8'h00);
    $display("pwm and buzzer test done");
  endtask

  task automatic t_timer2();
    wr(`TPW_R_T2LOW, 8'h05); // loads at once while disabled
    wr(`TPW_R_T2CTL2, 8'h38);
    wr(`TPW_R_IRQEN, 8'h20);
    wr(`TPW_R_PWRCTL, 8'h80);
    wr(`TPW_R_IRQFLG, 8'h00); // flags left set by the timer1 and pwm2 runs
    wr(`TPW_R_T2CTL1, 8'h05);
    chk(irq, 1'b0);
    tpw_pins_i.burst(1, 6);
    chk(irq, 1'b1);
    rd_chk(`TPW_R_IRQFLG, 8'h20);
    rd_chk(`TPW_R_T2LOW, 8'h00);
    rd_chk(5'h1f, 8'h00);
    // a write without byte select is acked but must not land
    sel <= 1'b0;
    wr(`TPW_R_DUTY2, 8'h55);
    sel <= 1'b1;
    rd_chk(`TPW_R_DUTY2, 8'h04);
    $display("timer2 test done");
  endtask

  // reset, then each scenario in turn
  initial begin
    error_cnt = 0;
    n_compared = 0;
    cyc_cnt = 0;
    rst = 1'b1;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 1'b1;
    adr = 5'h00; wdat = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk({p3, p3oe, p2, p2oe, irq}, 5'h00);
    rd_chk(`TPW_R_T0CNT, 8'h00);
    t_timer0();
    t_timer1();
    t_pwm();
    t_timer2();
    test_done();
  end
endmodule // testbench

`default_nettype wire
